// File: hw/cmr_diag.sv
// Purpose: local bus diagnostic status and parameter words
// Assumes: local bus master pulses err_set once the cause is known
// Notes: error bits are sticky until i_ack
module cmr_diag (
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire cmr_pkg::cmr_lbm_t i_lbm,
    input wire logic i_ack,
    output logic [15:0] o_status,
    output logic [15:0] o_param1,
    output logic [15:0] o_param2
);
    import cmr_pkg::*;
    typedef struct packed {
        logic [4:0] err;
        logic [15:0] p1;
        logic [15:0] p2;
    } cmr_diag_t;
    cmr_diag_t s_q, s_d;
    logic ready, active, run;

    assign ready = i_lbm.ready;
    assign active = ready && i_lbm.active;
    assign run = active && i_lbm.run;

    always_comb begin
        s_d = s_q;
        if (i_ack) begin
            s_d.err = 5'h00;
            s_d.p1 = 16'h0000;
            s_d.p2 = 16'h0000;
        end
        if (i_lbm.detect_start)
            s_d.err[BIT_DETECT] = 1'b1;
        // set wins over ack; a cause found ends localization
        if (i_lbm.err_set != 4'h0) begin
            s_d.err[3:0] = s_d.err[3:0] | i_lbm.err_set;
            s_d.err[BIT_DETECT] = 1'b0;
            s_d.p1 = i_lbm.err_info;
            s_d.p2 = i_lbm.err_extra;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset)
            s_q <= '0;
        else if (i_ce)
            s_q <= s_d;
    end

    // operating indicators never touch the parameter words
    assign o_status = {8'h00, ready, active, run, s_q.err};
    assign o_param1 = s_q.p1;
    assign o_param2 = s_q.p2;

    a_err_sticky: assert property (@(posedge i_core_clk) disable iff (i_reset)
        i_ce && s_q.err[3:0] != 4'h0 && !i_ack |=> s_q.err[3:0] != 4'h0)
        else $error("error bit cleared without acknowledge");
    a_param_idle: assert property (@(posedge i_core_clk) disable iff (i_reset)
        s_q.err[3:0] == 4'h0 |-> o_param1 == 16'h0000)
        else $error("parameter word nonzero with no error");
    a_detect_end: assert property (@(posedge i_core_clk) disable iff (i_reset)
        i_ce && s_q.err[BIT_DETECT] && i_lbm.err_set != 4'h0
        |=> !o_status[BIT_DETECT] && o_param1 == $past(i_lbm.err_info))
        else $error("localization not replaced by error bit");
    a_run_chain: assert property (@(posedge i_core_clk) disable iff (i_reset)
        o_status[BIT_RUN] |-> o_status[BIT_ACTIVE] && o_status[BIT_READY])
        else $error("run without active and ready");
    c_diag_err: cover property (@(posedge i_core_clk) disable iff (i_reset)
        s_q.err[BIT_DETECT] ##1 s_q.err[BIT_BUS]);
endmodule

// File: hw/cmr_top.sv
// Purpose: register map of the network coupler: special, parameter
//     channel, diagnostic and process data words
// Assumes: one request per cycle at most, answer one cycle later
// Notes: output image writes are dropped while a fault response is active
// Notes on behaviour
// - four read/write special words at 1280, 2000, 2002, 2006; 2004 ignores writes.
// - parameter channel words 6020 to 6173 are read/write.
// - read-only diagnostic words 7996 to 7999 in fixed order.
// - dynamic table: local inputs, x bus inputs, local outputs, y bus outputs.
// - static table: inputs 0-383 read-only, outputs 384-767 read/write.
// - status word has meaning only in bits 0 and 1.
// - bit 0 low on error, bit 1 high on network failure.
// - status reads 0000 on error, 0001 when clean, 0002 on net failure.
// - diagnostic bits 0-4: application, peripheral, bus, internal, localizing.
// - diagnostic bits 5-7: run, active, ready.
// - parameter word rewritten on error set, otherwise zero.
// - ready set after master self-test.
// - active added once configuration frame is running without error.
// - run added once data exchange starts.
// - operating indicators never use the parameter word.
// - error indications stay until acknowledged.
// - localization bit set on blocking error, outputs go to fault state.
// - found cause clears localization and sets the error bit.
// - internal error gives code, bus error gives location.
// - peripheral fault gives location, application error gives code.
// - watchdog expiry raises network failure and applies fault mode.
// - failure reason reads zero without a network failure.
module cmr_top #(
    parameter int CYC_PER_MS = cmr_pkg::CYCLES_PER_MS
) (
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire cmr_pkg::cmr_req_t i_req,
    output cmr_pkg::cmr_rsp_t o_rsp,
    input wire cmr_pkg::cmr_lbm_t i_lbm,
    input wire logic i_iimg_wr,
    input wire logic [8:0] i_iimg_addr,
    input wire logic [15:0] i_iimg_data,
    input wire logic [8:0] i_oimg_addr,
    output logic [15:0] o_oimg_data,
    input wire logic [7:0] i_local_di,
    output logic [3:0] o_local_do,
    output logic o_fault_active,
    output logic o_net_fail
);
    import cmr_pkg::*;

    typedef struct packed {
        logic [7:0] di_s1;
        logic [7:0] di_s2;
        logic [3:0] do_q;
        logic [15:0] conn_to;
        logic [15:0] wd_to;
        logic [15:0] fmode;
        logic [15:0] cmd;
        cmr_rsp_t rsp;
        logic [15:0] oimg;
        logic [3:0] do_out;
    } cmr_top_state_t;

    cmr_top_state_t s_q, s_d;
    logic [15:0] in_img [IMG_WORDS];
    logic [15:0] out_img [IMG_WORDS];
    logic [15:0] pc_mem [PC_WORDS];
    logic [15:0] status_word, diag_status, diag_p1, diag_p2, nf_reason;
    logic net_fail, fault, any_err;
    logic rd, wr, ack_net, ack_diag, out_wr, pc_wr, wd_trig;
    logic [8:0] out_idx;
    logic [7:0] pc_idx;
    logic [15:0] rdata;
    logic err;

    function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                      input logic [15:0] hi);
        in_range = a >= lo && a <= hi;
    endfunction

    function automatic logic [15:0] fault_word(input logic [8:0] idx, input logic [15:0] live,
                                               input logic [15:0] mode);
        if (mode == FMODE_HOLD)
            fault_word = live;
        else if (mode == FMODE_RESET && idx >= 9'(IMG_WORDS / 2))
            fault_word = ANALOG_DEFAULT;
        else
            fault_word = 16'h0000;
    endfunction

    cmr_diag u_diag (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_ce(i_ce),
        .i_lbm(i_lbm),
        .i_ack(ack_diag),
        .o_status(diag_status),
        .o_param1(diag_p1),
        .o_param2(diag_p2)
    );

    cmr_watchdog #(
        .CYC_PER_MS(CYC_PER_MS)
    ) u_wd (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_ce(i_ce),
        .i_trigger(wd_trig),
        .i_ack(ack_net),
        .i_timeout_ms(s_q.wd_to),
        .o_net_fail(net_fail),
        .o_reason(nf_reason)
    );

    assign rd = i_req.valid && !i_req.write;
    assign wr = i_req.valid && i_req.write;
    assign any_err = diag_status[BIT_DETECT:BIT_USER] != 5'h00;
    assign status_word = {14'h0000, net_fail, !(any_err || net_fail)};
    assign fault = net_fail || diag_status[BIT_DETECT];
    assign ack_net = wr && i_req.addr == ADDR_COMMAND && i_req.wdata == CMD_ACK_NET_FAIL;
    assign ack_diag = wr && i_req.addr == ADDR_COMMAND && i_req.wdata == CMD_ACK_DIAG;
    assign pc_idx = 8'(i_req.addr - ADDR_PC_FIRST);

    // process output address to image index; reads never retrigger
    always_comb begin
        out_wr = 1'b0;
        out_idx = 9'h000;
        if (in_range(i_req.addr, ADDR_ST_DO_FIRST, ADDR_ST_AO_LAST)) begin
            out_wr = wr;
            out_idx = 9'(i_req.addr - ADDR_ST_DO_FIRST);
        end else if (in_range(i_req.addr, ADDR_DYN_OUT_FIRST, ADDR_DYN_OUT_LAST)) begin
            out_wr = wr;
            out_idx = 9'(i_req.addr - ADDR_DYN_OUT_FIRST);
        end
    end
    assign wd_trig = out_wr || (wr && i_req.addr == ADDR_LOCAL_DO);
    assign pc_wr = wr && in_range(i_req.addr, ADDR_PC_FIRST, ADDR_PC_LAST);

    // read mux and error answer for unmapped or read-only writes
    always_comb begin
        rdata = 16'h0000;
        err = 1'b0;
        if (i_req.addr == ADDR_CONN_TIMEOUT) begin
            rdata = s_q.conn_to;
        end else if (i_req.addr == ADDR_WD_TIMEOUT) begin
            rdata = s_q.wd_to;
        end else if (i_req.addr == ADDR_FAULT_MODE) begin
            rdata = s_q.fmode;
        end else if (i_req.addr == ADDR_NF_REASON) begin
            rdata = nf_reason;
        end else if (i_req.addr == ADDR_COMMAND) begin
            rdata = s_q.cmd;
        end else if (in_range(i_req.addr, ADDR_PC_FIRST, ADDR_PC_LAST)) begin
            rdata = pc_mem[pc_idx];
        end else if (i_req.addr == ADDR_STATUS) begin
            rdata = status_word;
            err = i_req.write;
        end else if (i_req.addr == ADDR_DIAG_STATUS) begin
            rdata = diag_status;
            err = i_req.write;
        end else if (i_req.addr == ADDR_DIAG_PARAM1) begin
            rdata = diag_p1;
            err = i_req.write;
        end else if (i_req.addr == ADDR_DIAG_PARAM2) begin
            rdata = diag_p2;
            err = i_req.write;
        end else if (i_req.addr == ADDR_LOCAL_DI) begin
            rdata = {8'h00, s_q.di_s2};
            err = i_req.write;
        end else if (in_range(i_req.addr, ADDR_DYN_IN_FIRST, ADDR_DYN_IN_LAST)) begin
            rdata = in_img[9'(i_req.addr - ADDR_DYN_IN_FIRST)];
            err = i_req.write;
        end else if (i_req.addr == ADDR_LOCAL_DO) begin
            rdata = {12'h000, s_q.do_q};
        end else if (in_range(i_req.addr, ADDR_DYN_OUT_FIRST, ADDR_DYN_OUT_LAST)) begin
            rdata = out_img[out_idx];
        end else if (in_range(i_req.addr, ADDR_ST_DI_FIRST, ADDR_ST_AI_LAST)) begin
            rdata = in_img[9'(i_req.addr - ADDR_ST_DI_FIRST)];
            err = i_req.write;
        end else if (in_range(i_req.addr, ADDR_ST_DO_FIRST, ADDR_ST_AO_LAST)) begin
            rdata = out_img[out_idx];
        end else begin
            err = 1'b1;
        end
    end

    always_comb begin
        s_d = s_q;
        s_d.di_s1 = i_local_di;
        s_d.di_s2 = s_q.di_s1;
        s_d.rsp.valid = i_req.valid;
        s_d.rsp.err = i_req.valid && err;
        s_d.rsp.rdata = rd ? rdata : 16'h0000;
        if (wr) begin
            if (i_req.addr == ADDR_CONN_TIMEOUT)
                s_d.conn_to = i_req.wdata;
            else if (i_req.addr == ADDR_WD_TIMEOUT)
                s_d.wd_to = i_req.wdata;
            else if (i_req.addr == ADDR_FAULT_MODE)
                s_d.fmode = i_req.wdata;
            else if (i_req.addr == ADDR_COMMAND)
                s_d.cmd = i_req.wdata;
            else if (i_req.addr == ADDR_LOCAL_DO && !fault)
                s_d.do_q = i_req.wdata[3:0];
        end
        s_d.oimg = fault ? fault_word(i_oimg_addr, out_img[i_oimg_addr], s_q.fmode)
                         : out_img[i_oimg_addr];
        if (!fault)
            s_d.do_out = s_q.do_q;
        else if (s_q.fmode != FMODE_HOLD)
            s_d.do_out = 4'h0;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            s_q <= '0;
            s_q.conn_to <= RST_CONN_TIMEOUT;
            s_q.wd_to <= RST_WD_TIMEOUT;
            s_q.fmode <= RST_FAULT_MODE;
        end else if (i_ce) begin
            s_q <= s_d;
        end
    end

    // images have no reset: software and the local bus fill them
    always_ff @(posedge i_core_clk) begin
        if (i_ce) begin
            if (out_wr && !fault)
                out_img[out_idx] <= i_req.wdata;
            if (pc_wr)
                pc_mem[pc_idx] <= i_req.wdata;
            if (i_iimg_wr)
                in_img[i_iimg_addr] <= i_iimg_data;
        end
    end

    assign o_rsp = s_q.rsp;
    assign o_oimg_data = s_q.oimg;
    assign o_local_do = s_q.do_out;
    assign o_fault_active = fault;
    assign o_net_fail = net_fail;

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_reset);

    a_status_reserved: assert property (
        i_ce && rd && i_req.addr == ADDR_STATUS |=> o_rsp.valid && o_rsp.rdata[15:2] == 14'h0000
    )
        else $error("status reserved bits not zero");
    a_status_clean: assert property (
        i_ce && rd && i_req.addr == ADDR_STATUS && !any_err && !net_fail
        |=> o_rsp.rdata == 16'h0001
    )
        else $error("clean status did not read 0001");
    a_status_netfail: assert property (
        i_ce && rd && i_req.addr == ADDR_STATUS && net_fail |=> o_rsp.rdata == 16'h0002
    )
        else $error("net failure status did not read 0002");
    a_ro_write: assert property (
        i_ce && wr && in_range(i_req.addr, ADDR_STATUS, ADDR_DIAG_PARAM2)
        |=> o_rsp.err
    )
        else $error("write to read-only word not refused");
    a_pc_readback: assert property (
        i_ce && pc_wr ##1 !i_req.valid ##1 (i_ce && rd && i_req.addr == $past(i_req.addr, 2))
        |=> o_rsp.rdata == $past(i_req.wdata, 3)
    )
        else $error("parameter channel word lost");
    a_fault_zero: assert property (
        i_ce && fault && s_q.fmode == FMODE_STANDARD |=> o_local_do == 4'h0
    )
        else $error("outputs not in fault state");
    a_special_rw: assert property (
        i_ce && wr && i_req.addr == ADDR_WD_TIMEOUT ##1 !i_req.valid
        ##1 (i_ce && rd && i_req.addr == ADDR_WD_TIMEOUT)
        |=> o_rsp.rdata == $past(i_req.wdata, 3) && !o_rsp.err
    )
        else $error("special word did not read back");
    a_dyn_di: assert property (
        i_ce && rd && i_req.addr == ADDR_LOCAL_DI |=> o_rsp.rdata == {8'h00, $past(s_q.di_s2)}
    )
        else $error("local inputs misread");

    c_pc_access: cover property (pc_wr ##2 rd);
    c_dyn_out: cover property (wr && i_req.addr == ADDR_DYN_OUT_FIRST);
    c_fault_ack: cover property (net_fail ##[1:20] !net_fail);
endmodule

// File: hw/cmr_watchdog.sv
// Purpose: process data watchdog raising the network failure
// Assumes: i_trigger pulses on every process output write
// Notes: a zero timeout only disables it while not yet armed
module cmr_watchdog #(
    parameter int CYC_PER_MS = cmr_pkg::CYCLES_PER_MS
) (
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic i_trigger,
    input wire logic i_ack,
    input wire logic [15:0] i_timeout_ms,
    output logic o_net_fail,
    output logic [15:0] o_reason
);
    import cmr_pkg::*;
    typedef enum logic [2:0] {
        WD_INIT = 3'b001,
        WD_ARMED = 3'b010,
        WD_FAILED = 3'b100
    } cmr_wd_state_t;
    typedef struct packed {
        cmr_wd_state_t st;
        logic [15:0] pre;
        logic [15:0] ms;
    } cmr_wd_t;
    cmr_wd_t s_q, s_d;
    logic tick;

    assign tick = s_q.pre == 16'(CYC_PER_MS - 1);

    always_comb begin
        s_d = s_q;
        s_d.pre = tick ? 16'h0000 : s_q.pre + 16'h0001;
        case (s_q.st)
            WD_INIT: begin
                if (i_trigger && i_timeout_ms != 16'h0000) begin
                    s_d.st = WD_ARMED;
                    s_d.pre = 16'h0000;
                    s_d.ms = 16'h0000;
                end
            end
            WD_ARMED: begin
                if (i_trigger) begin
                    s_d.pre = 16'h0000;
                    s_d.ms = 16'h0000;
                end else if (tick) begin
                    s_d.ms = s_q.ms + 16'h0001;
                    if (s_q.ms + 16'h0001 >= i_timeout_ms)
                        s_d.st = WD_FAILED;
                end
            end
            WD_FAILED: begin
                // acknowledging restarts the timeout immediately
                if (i_ack) begin
                    s_d.st = WD_ARMED;
                    s_d.pre = 16'h0000;
                    s_d.ms = 16'h0000;
                end
            end
            default: s_d.st = WD_INIT;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset)
            s_q <= '{st: WD_INIT, pre: 16'h0000, ms: 16'h0000};
        else if (i_ce)
            s_q <= s_d;
    end

    assign o_net_fail = s_q.st == WD_FAILED;
    assign o_reason = o_net_fail ? NF_REASON_WATCHDOG : 16'h0000;

    a_reason_zero: assert property (@(posedge i_core_clk) disable iff (i_reset)
        !o_net_fail |-> o_reason == 16'h0000)
        else $error("reason nonzero without network failure");
    a_wd_expire: assert property (@(posedge i_core_clk) disable iff (i_reset)
        i_ce && s_q.st == WD_ARMED && !i_trigger && tick && s_q.ms + 16'h0001 >= i_timeout_ms
        |=> o_net_fail && o_reason == NF_REASON_WATCHDOG)
        else $error("watchdog expiry did not raise network failure");
    c_net_fail: cover property (@(posedge i_core_clk) disable iff (i_reset) $rose(o_net_fail));
endmodule

// File: shared/cmr_pkg.sv
// Purpose: shared constants and carriers for the coupler register map
// Assumes: word addresses as seen by the register client, 16-bit data
// Notes: dynamic table sizes are fixed at build time
package cmr_pkg;
    localparam logic [15:0] ADDR_CONN_TIMEOUT = 16'h0500;
    localparam logic [15:0] ADDR_WD_TIMEOUT = 16'h07d0;
    localparam logic [15:0] ADDR_FAULT_MODE = 16'h07d2;
    localparam logic [15:0] ADDR_NF_REASON = 16'h07d4;
    localparam logic [15:0] ADDR_COMMAND = 16'h07d6;
    localparam logic [15:0] ADDR_PC_FIRST = 16'h1784;
    localparam logic [15:0] ADDR_PC_LAST = 16'h181d;
    localparam logic [15:0] ADDR_STATUS = 16'h1f3c;
    localparam logic [15:0] ADDR_DIAG_STATUS = 16'h1f3d;
    localparam logic [15:0] ADDR_DIAG_PARAM1 = 16'h1f3e;
    localparam logic [15:0] ADDR_DIAG_PARAM2 = 16'h1f3f;
    localparam logic [15:0] ADDR_LOCAL_DI = 16'h1f40;
    localparam int DYN_X_WORDS = 8;
    localparam int DYN_Y_WORDS = 8;
    localparam logic [15:0] ADDR_DYN_IN_FIRST = 16'h1f41;
    localparam logic [15:0] ADDR_DYN_IN_LAST = 16'h1f48;
    localparam logic [15:0] ADDR_LOCAL_DO = 16'h1f49;
    localparam logic [15:0] ADDR_DYN_OUT_FIRST = 16'h1f4a;
    localparam logic [15:0] ADDR_DYN_OUT_LAST = 16'h1f51;
    localparam logic [15:0] ADDR_ST_DI_FIRST = 16'h0000;
    localparam logic [15:0] ADDR_ST_AI_LAST = 16'h017f;
    localparam logic [15:0] ADDR_ST_DO_FIRST = 16'h0180;
    localparam logic [15:0] ADDR_ST_AO_FIRST = 16'h0240;
    localparam logic [15:0] ADDR_ST_AO_LAST = 16'h02ff;
    localparam int IMG_WORDS = 384;
    localparam int PC_WORDS = 154;
    localparam logic [15:0] RST_WD_TIMEOUT = 16'h01f4;
    localparam logic [15:0] RST_CONN_TIMEOUT = 16'h0000;
    localparam logic [15:0] RST_FAULT_MODE = 16'h0001;
    localparam logic [15:0] FMODE_STANDARD = 16'h0000;
    localparam logic [15:0] FMODE_RESET = 16'h0001;
    localparam logic [15:0] FMODE_HOLD = 16'h0002;
    localparam logic [15:0] ANALOG_DEFAULT = 16'h0000;
    localparam logic [15:0] CMD_ACK_DIAG = 16'h0001;
    localparam logic [15:0] CMD_ACK_NET_FAIL = 16'h0002;
    localparam logic [15:0] NF_REASON_WATCHDOG = 16'h000c;
    localparam int CLK_HZ = 10000000;
    localparam int MS_PER_S = 1000;
    localparam int CYCLES_PER_MS = CLK_HZ / MS_PER_S;
    localparam int BIT_USER = 0;
    localparam int BIT_PERIPH = 1;
    localparam int BIT_BUS = 2;
    localparam int BIT_CTRL = 3;
    localparam int BIT_DETECT = 4;
    localparam int BIT_RUN = 5;
    localparam int BIT_ACTIVE = 6;
    localparam int BIT_READY = 7;
    localparam int ST_BIT_OK = 0;
    localparam int ST_BIT_NET_FAIL = 1;

    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        logic [15:0] wdata;
    } cmr_req_t;

    typedef struct packed {
        logic valid;
        logic err;
        logic [15:0] rdata;
    } cmr_rsp_t;

    typedef struct packed {
        logic ready;
        logic active;
        logic run;
        logic detect_start;
        logic [3:0] err_set;
        logic [15:0] err_info;
        logic [15:0] err_extra;
    } cmr_lbm_t;
endpackage

// File: testbench/cmr_client_model.sv
// Purpose: register client on the far side, one word per request
// Assumes: request taken at the rising edge, answer one cycle later
// Notes: released address and data show the inverse, never stale values
module cmr_client_model (
    input wire logic i_core_clk,
    input wire cmr_pkg::cmr_rsp_t i_rsp,
    output cmr_pkg::cmr_req_t o_req
);
    timeunit 1ns;
    timeprecision 1ns;
    import cmr_pkg::*;
    initial o_req = '0;
    task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] wd,
                        output logic [15:0] rd, output logic er);
        int n;
        n = 0;
        rd = 'x;
        er = 'x;
        @(negedge i_core_clk);
        o_req = '{valid: 1'h1, write: w, addr: a, wdata: wd};
        @(negedge i_core_clk);
        o_req = '{valid: 1'h0, write: ~w, addr: ~a, wdata: ~wd};
        while (i_rsp.valid !== 1'h1 && n < 4) begin
            @(negedge i_core_clk);
            n++;
        end
        if (i_rsp.valid === 1'h1) begin
            rd = i_rsp.rdata;
            er = i_rsp.err;
        end
    endtask
endmodule

// File: testbench/coupler_modbus_register_map_diag_tb_top.sv
// Purpose: register map, diagnostic and watchdog checks at the ports
// Assumes: watchdog built with 10 cycles per ms to keep the run short
// Notes: inputs move on the falling edge only
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module coupler_modbus_register_map_diag_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import cmr_pkg::*;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic ce = 1'h1;
    cmr_req_t req;
    cmr_rsp_t rsp;
    cmr_lbm_t lbm = '0;
    logic iw = 1'h0;
    logic [15:0] id = 16'h0000;
    logic [15:0] oimg;
    logic [3:0] ldo;
    logic fa;
    logic nf;
    int mismatches = 0;
    int num_checks = 0;
    logic [15:0] ro[8] = '{ADDR_STATUS, ADDR_DIAG_STATUS, ADDR_DIAG_PARAM1, ADDR_DIAG_PARAM2,
        ADDR_LOCAL_DI, ADDR_DYN_IN_FIRST, ADDR_ST_DI_FIRST, ADDR_ST_AI_LAST};
    logic [15:0] rw[3] = '{ADDR_CONN_TIMEOUT, ADDR_PC_FIRST, ADDR_PC_LAST};
    always #50 clk = ~clk;
    cmr_top #(.CYC_PER_MS(10)) DUT (.i_core_clk(clk), .i_reset(rst), .i_ce(ce),
        .i_req(req), .o_rsp(rsp), .i_lbm(lbm), .i_iimg_wr(iw), .i_iimg_addr(9'h000),
        .i_iimg_data(id), .i_oimg_addr(9'h000), .o_oimg_data(oimg), .i_local_di(8'h5a),
        .o_local_do(ldo), .o_fault_active(fa), .o_net_fail(nf));
    cmr_client_model cl (.i_core_clk(clk), .i_rsp(rsp), .o_req(req));
    task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] wd,
                       input logic [15:0] e, input logic ee);
        logic [15:0] d;
        logic er;
        cl.xfer(w, a, wd, d, er);
        if (ee) `CHK(er, ee)
        else `CHK({er, d}, {ee, e})
    endtask
    task automatic done(input string s);
        $display("test %s finished, mismatches so far %0d", s, mismatches);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #1_000_000;
        mismatches++;
        print_verdict();
    end
    initial begin
        repeat (12) @(posedge clk);
        @(negedge clk) rst = 1'h0;
        acc(1'h0, ADDR_WD_TIMEOUT, 16'h0000, RST_WD_TIMEOUT, 1'h0);
        acc(1'h0, ADDR_FAULT_MODE, 16'h0000, RST_FAULT_MODE, 1'h0);
        acc(1'h1, ADDR_NF_REASON, 16'h0007, 16'h0000, 1'h0);
        acc(1'h0, ADDR_NF_REASON, 16'h0000, 16'h0000, 1'h0);
        acc(1'h0, ADDR_STATUS, 16'h0000, 16'h0001, 1'h0);
        foreach (rw[i]) begin
            acc(1'h1, rw[i], 16'ha5c0 + 16'(i), 16'h0000, 1'h0);
            acc(1'h0, rw[i], 16'h0000, 16'ha5c0 + 16'(i), 1'h0);
        end
        acc(1'h1, ADDR_PC_LAST + 16'h0001, 16'h0001, 16'h0000, 1'h1);
        acc(1'h0, ADDR_PC_FIRST - 16'h0001, 16'h0000, 16'h0000, 1'h1);
        foreach (ro[i]) acc(1'h1, ro[i], 16'hffff, 16'h0000, 1'h1);
        acc(1'h0, ADDR_STATUS, 16'h0000, 16'h0001, 1'h0);
        done("map");
        @(negedge clk) {iw, id} = {1'h1, 16'h1234};
        @(negedge clk) iw = 1'h0;
        acc(1'h0, ADDR_ST_DI_FIRST, 16'h0000, 16'h1234, 1'h0);
        acc(1'h0, ADDR_DYN_IN_FIRST, 16'h0000, 16'h1234, 1'h0);
        acc(1'h0, ADDR_LOCAL_DI, 16'h0000, 16'h005a, 1'h0);
        acc(1'h1, ADDR_ST_DO_FIRST, 16'hbeef, 16'h0000, 1'h0);
        acc(1'h1, ADDR_ST_AO_LAST, 16'h0a0a, 16'h0000, 1'h0);
        acc(1'h0, ADDR_ST_AO_LAST, 16'h0000, 16'h0a0a, 1'h0);
        acc(1'h1, ADDR_LOCAL_DO, 16'h000f, 16'h0000, 1'h0);
        @(negedge clk);
        `CHK(oimg, 16'hbeef)
        `CHK(ldo, 4'hf)
        acc(1'h0, ADDR_LOCAL_DO, 16'h0000, 16'h000f, 1'h0);
        acc(1'h1, ADDR_DYN_OUT_FIRST, 16'h1357, 16'h0000, 1'h0);
        acc(1'h0, ADDR_ST_DO_FIRST, 16'h0000, 16'h1357, 1'h0);
        @(negedge clk) {ce, iw, id} = {1'h0, 1'h1, 16'h4321};
        @(negedge clk) {ce, iw} = 2'h2;
        acc(1'h0, ADDR_ST_DI_FIRST, 16'h0000, 16'h1234, 1'h0);
        done("process");
        @(negedge clk) {lbm.ready, lbm.active, lbm.run} = 3'h7;
        acc(1'h0, ADDR_DIAG_STATUS, 16'h0000, 16'h00e0, 1'h0);
        acc(1'h0, ADDR_DIAG_PARAM1, 16'h0000, 16'h0000, 1'h0);
        for (int k = 0; k < 4; k++) begin
            @(negedge clk) lbm.detect_start = 1'h1;
            @(negedge clk) lbm.detect_start = 1'h0;
            `CHK(fa, 1'h1)
            acc(1'h0, ADDR_DIAG_STATUS, 16'h0000, 16'h00f0, 1'h0);
            @(negedge clk) lbm.err_set = 4'h1 << k;
            {lbm.err_info, lbm.err_extra} = {16'h0100 + 16'(k), 16'h0042};
            @(negedge clk) lbm.err_set = 4'h0;
            {lbm.err_info, lbm.err_extra} = 32'h0000_0000;
            acc(1'h0, ADDR_DIAG_STATUS, 16'h0000, 16'h00e0 | (16'h0001 << k), 1'h0);
            acc(1'h0, ADDR_DIAG_PARAM1, 16'h0000, 16'h0100 + 16'(k), 1'h0);
            acc(1'h0, ADDR_DIAG_PARAM2, 16'h0000, 16'h0042, 1'h0);
            acc(1'h0, ADDR_STATUS, 16'h0000, 16'h0000, 1'h0);
            acc(1'h0, ADDR_DIAG_STATUS, 16'h0000, 16'h00e0 | (16'h0001 << k), 1'h0);
            acc(1'h1, ADDR_COMMAND, CMD_ACK_DIAG, 16'h0000, 1'h0);
            acc(1'h0, ADDR_DIAG_PARAM1, 16'h0000, 16'h0000, 1'h0);
            acc(1'h0, ADDR_STATUS, 16'h0000, 16'h0001, 1'h0);
        end
        done("diag");
        acc(1'h1, ADDR_FAULT_MODE, FMODE_STANDARD, 16'h0000, 1'h0);
        acc(1'h1, ADDR_WD_TIMEOUT, 16'h0003, 16'h0000, 1'h0);
        acc(1'h0, ADDR_WD_TIMEOUT, 16'h0000, 16'h0003, 1'h0);
        acc(1'h1, 16'h0181, 16'h0005, 16'h0000, 1'h0);
        repeat (60) @(negedge clk);
        `CHK(nf, 1'h1)
        `CHK(ldo, 4'h0)
        `CHK(oimg, 16'h0000)
        acc(1'h0, ADDR_STATUS, 16'h0000, 16'h0002, 1'h0);
        acc(1'h0, ADDR_NF_REASON, 16'h0000, NF_REASON_WATCHDOG, 1'h0);
        acc(1'h1, ADDR_COMMAND, CMD_ACK_NET_FAIL, 16'h0000, 1'h0);
        acc(1'h0, ADDR_NF_REASON, 16'h0000, 16'h0000, 1'h0);
        acc(1'h1, ADDR_FAULT_MODE, FMODE_HOLD, 16'h0000, 1'h0);
        repeat (60) @(negedge clk);
        `CHK(nf, 1'h1)
        `CHK(ldo, 4'hf)
        `CHK(oimg, 16'h1357)
        done("watchdog");
        print_verdict();
    end
endmodule
